/* File: rtl/qcs_pkg.sv */
package qcs_pkg;
  // register byte offsets
  localparam logic [7:0] QCS_CTRL_OFF = 8'h00;
  localparam logic [7:0] QCS_WEIGHT_OFF = 8'h04;
  localparam logic [7:0] QCS_TAG_MAP_OFF = 8'h08;
  localparam logic [7:0] QCS_STATUS_OFF = 8'h0c;
  localparam logic [7:0] QCS_DS_MAP0_OFF = 8'h10;
  localparam logic [7:0] QCS_PORT_MAP_OFF = 8'h20;
  // control fields
  localparam int QCS_CTRL_PORT_BIT = 0;
  localparam int QCS_CTRL_TAG_BIT = 1;
  localparam int QCS_CTRL_DS_BIT = 2;
  localparam int QCS_CTRL_MODE_LSB = 4;
  // reset values
  localparam logic [31:0] QCS_WEIGHT_RST = 32'h0804_0201;
  localparam logic [15:0] QCS_TAG_MAP_RST = 16'hfa41;
  localparam logic [31:0] QCS_DS_MAP_RST = 32'h0000_0000;
  localparam logic [31:0] QCS_PORT_MAP_RST = 32'h0000_0000;
  // hybrid group weights for queues 0, 1, 2, then the equal-mode weight
  localparam logic [7:0] QCS_HYB_W0 = 8'h01;
  localparam logic [7:0] QCS_HYB_W1 = 8'h02;
  localparam logic [7:0] QCS_HYB_W2 = 8'h04;
  localparam logic [7:0] QCS_EQU_W = 8'h01;
  // structure
  localparam int QCS_NQ = 4;
  localparam int QCS_DATA_W = 16;
  localparam int QCS_FIFO_D = 16;
  localparam int QCS_PORT_W = 4;
  typedef enum logic [1:0] {
    QCS_MODE_SP = 2'b00,
    QCS_MODE_WRR = 2'b01,
    QCS_MODE_HYB = 2'b11,
    QCS_MODE_EQU = 2'b10
  } qcs_mode_e;
endpackage : qcs_pkg

/* File: rtl/qcs_top.sv */
`timescale 1ns/100ps

// plain synchronous fifo; one entry is one whole packet descriptor
module qcs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, low
  input wire logic wr_valid, // push request
  output logic wr_ready, // not full
  input wire logic [WIDTH-1:0] wr_data, // push data
  output logic rd_valid, // not empty
  input wire logic rd_ready, // pop
  output logic [WIDTH-1:0] rd_data, // head entry
  output logic [$clog2(DEPTH):0] count // occupancy
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire push = wr_valid && wr_ready;
  wire pop = rd_valid && rd_ready;

  // honest flags straight from occupancy
  assign wr_ready = (count_q != DEPTH[AW:0]);
  assign rd_valid = (count_q != '0);
  assign rd_data = mem[rd_ptr_q];
  assign count = count_q;

  // storage has no reset; only pointers and count need a defined value
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_q] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push && !pop) count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end
endmodule : qcs_fifo

module qcs_top
  import qcs_pkg::*;
(
  input wire logic pclk, // 125 MHz core clock
  input wire logic presetn, // async reset, low
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error on unmapped
  input wire logic in_valid, // packet descriptor offered
  output logic in_ready, // descriptor taken when high
  input wire logic [QCS_PORT_W-1:0] in_port, // ingress port number
  input wire logic in_tagged, // packet carries 802.1Q tag
  input wire logic [2:0] in_pcp, // tag priority field
  input wire logic in_is_ip, // packet is IP
  input wire logic [7:0] in_ds, // IP DS byte
  input wire logic [QCS_DATA_W-1:0] in_data, // packet handle
  output logic out_valid, // descriptor to transmit
  input wire logic out_ready, // transmitter takes it
  output logic [1:0] out_queue, // queue it came from
  output logic [QCS_DATA_W-1:0] out_data // packet handle
);
  localparam int DW = QCS_DATA_W;
  localparam int CW = $clog2(QCS_FIFO_D) + 1;

  // ---------------- register file ----------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic tag_en_q;
  logic ds_en_q;
  qcs_mode_e mode_q;
  logic [31:0] weight_q;
  logic [15:0] tag_map_q;
  logic [31:0] ds_map_q [4];
  logic [31:0] port_map_q;
  logic [CW-1:0] cnt [QCS_NQ];

  wire setup = psel && !penable;
  wire wr_en = psel && penable && pready_q && pwrite;
  wire sel_ctrl = (paddr == QCS_CTRL_OFF);
  wire sel_weight = (paddr == QCS_WEIGHT_OFF);
  wire sel_tag = (paddr == QCS_TAG_MAP_OFF);
  wire sel_status = (paddr == QCS_STATUS_OFF);
  wire sel_ds = (paddr[7:4] == QCS_DS_MAP0_OFF[7:4]) && (paddr[1:0] == 2'b00);
  wire sel_port = (paddr == QCS_PORT_MAP_OFF);
  wire mapped = sel_ctrl || sel_weight || sel_tag || sel_status || sel_ds || sel_port;
  wire [1:0] ds_idx = paddr[3:2];
  // port source is always on; it is the fallback of the other two
  wire [31:0] ctrl_rd = {26'h0, mode_q, 1'b0, ds_en_q, tag_en_q, 1'b1};
  wire [31:0] status_rd = {12'h0, cnt[3][4:0], cnt[2][4:0], cnt[1][4:0], cnt[0][4:0]};

  // read mux, registered in the setup cycle so the access phase answers at once
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (sel_ctrl) rd_mux = ctrl_rd;
    if (sel_weight) rd_mux = weight_q;
    if (sel_tag) rd_mux = {16'h0, tag_map_q};
    if (sel_status) rd_mux = status_rd;
    if (sel_ds) rd_mux = ds_map_q[ds_idx];
    if (sel_port) rd_mux = port_map_q;
  end

  // apb handshake: one wait-free access phase after each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // configuration writes take effect at the completing edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_en_q <= 1'b0;
      ds_en_q <= 1'b0;
      mode_q <= QCS_MODE_SP;
      weight_q <= QCS_WEIGHT_RST;
      tag_map_q <= QCS_TAG_MAP_RST;
      port_map_q <= QCS_PORT_MAP_RST;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        tag_en_q <= pwdata[QCS_CTRL_TAG_BIT];
        ds_en_q <= pwdata[QCS_CTRL_DS_BIT];
        mode_q <= qcs_mode_e'(pwdata[QCS_CTRL_MODE_LSB +: 2]);
      end
      if (sel_weight) weight_q <= pwdata;
      if (sel_tag) tag_map_q <= pwdata[15:0];
      if (sel_port) port_map_q <= pwdata;
    end
  end

  // dscp table, four words of sixteen two-bit entries
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ds
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ds_map_q[gi] <= QCS_DS_MAP_RST;
        end else if (wr_en && sel_ds && ds_idx == gi) begin
          ds_map_q[gi] <= pwdata;
        end
      end
    end
  endgenerate

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ---------------- classification ----------------
  // dscp is the six msbs; the two reserved lsbs are dropped here
  wire [5:0] dscp = in_ds[7:2];
  wire [1:0] q_port = port_map_q[{in_port, 1'b0} +: 2];
  wire [1:0] q_tag = tag_map_q[{in_pcp, 1'b0} +: 2];
  wire [1:0] q_ds = ds_map_q[dscp[5:4]][{dscp[3:0], 1'b0} +: 2];
  wire use_ds = ds_en_q && in_is_ip;
  // a tag is honoured under tag mode, and for non-IP traffic under ds mode
  wire use_tag = (tag_en_q || ds_en_q) && in_tagged;
  wire [1:0] q_class = use_ds ? q_ds : (use_tag ? q_tag : q_port);

  // one-deep ingress stage; fifo back-pressure stalls in_ready
  logic stage_full_q;
  logic in_ready_q;
  logic [1:0] stage_q_q;
  logic [DW-1:0] stage_data_q;
  logic [QCS_NQ-1:0] f_wr_ready;
  logic [QCS_NQ-1:0] f_rd_valid;
  logic [QCS_NQ-1:0] f_pop;
  logic [DW-1:0] f_rd_data [QCS_NQ];
  wire accept = in_valid && in_ready_q;
  wire drain = stage_full_q && f_wr_ready[stage_q_q];
  wire stage_full_d = accept || (stage_full_q && !drain);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_full_q <= 1'b0;
      in_ready_q <= 1'b1;
      stage_q_q <= 2'b00;
      stage_data_q <= '0;
    end else begin
      stage_full_q <= stage_full_d;
      in_ready_q <= !stage_full_d;
      if (accept) begin
        stage_q_q <= q_class;
        stage_data_q <= in_data;
      end
    end
  end
  assign in_ready = in_ready_q;

  // four egress queues, index 3 the highest priority
  generate
    for (gi = 0; gi < QCS_NQ; gi++) begin : g_q
      qcs_fifo #(
        .WIDTH(DW),
        .DEPTH(QCS_FIFO_D)
      ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .wr_valid(stage_full_q && stage_q_q == gi),
        .wr_ready(f_wr_ready[gi]),
        .wr_data(stage_data_q),
        .rd_valid(f_rd_valid[gi]),
        .rd_ready(f_pop[gi]),
        .rd_data(f_rd_data[gi]),
        .count(cnt[gi])
      );
    end
  endgenerate

  // ---------------- scheduler ----------------
  logic [1:0] rr_ptr_q;
  logic [7:0] rr_cnt_q;
  logic out_valid_q;
  logic [1:0] out_queue_q;
  logic [DW-1:0] out_data_q;
  logic [1:0] pick;
  logic found;
  logic [1:0] idx;
  logic [7:0] w_pick;
  logic [7:0] base_cnt;
  logic [7:0] cnt_inc;
  logic strict_pick;
  logic [QCS_NQ-1:0] elig;

  wire load = (!out_valid_q || out_ready) && (f_rd_valid != '0);
  wire hyb_strict = (mode_q == QCS_MODE_HYB) && f_rd_valid[3];

  // the hybrid group excludes queue 3 from the weighted search
  assign elig = (mode_q == QCS_MODE_HYB) ? (f_rd_valid & 4'h7) : f_rd_valid;

  // grant selection; each grant moves one whole descriptor
  always_comb begin
    pick = rr_ptr_q;
    found = 1'b0;
    idx = 2'b00;
    w_pick = QCS_EQU_W;
    strict_pick = 1'b0;
    if (mode_q == QCS_MODE_SP) begin
      strict_pick = 1'b1;
      for (int k = 0; k < QCS_NQ; k++) begin
        if (f_rd_valid[k]) pick = 2'(k);
      end
    end else if (hyb_strict) begin
      strict_pick = 1'b1;
      pick = 2'd3;
    end else begin
      // first eligible queue from the pointer in cyclic order
      for (int k = 0; k < QCS_NQ; k++) begin
        idx = rr_ptr_q + 2'(k);
        if (!found && elig[idx]) begin
          pick = idx;
          found = 1'b1;
        end
      end
    end
    case (mode_q)
      QCS_MODE_WRR: w_pick = weight_q[{pick, 3'b000} +: 8];
      QCS_MODE_HYB: begin
        case (pick)
          2'd0: w_pick = QCS_HYB_W0;
          2'd1: w_pick = QCS_HYB_W1;
          default: w_pick = QCS_HYB_W2;
        endcase
      end
      default: w_pick = QCS_EQU_W;
    endcase
    // a zero weight would starve the queue, so treat it as one
    if (w_pick == 8'h00) w_pick = QCS_EQU_W;
    // a skipped turn restarts the credit at the queue actually served
    base_cnt = (pick == rr_ptr_q) ? rr_cnt_q : 8'h00;
    cnt_inc = base_cnt + 8'h01;
  end

  assign f_pop = load ? (4'b0001 << pick) : 4'b0000;

  // output register and round-robin credit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rr_ptr_q <= 2'b00;
      rr_cnt_q <= 8'h00;
      out_valid_q <= 1'b0;
      out_queue_q <= 2'b00;
      out_data_q <= '0;
    end else begin
      if (load) begin
        out_valid_q <= 1'b1;
        out_queue_q <= pick;
        out_data_q <= f_rd_data[pick];
        if (!strict_pick) begin
          if (cnt_inc >= w_pick) begin
            rr_ptr_q <= pick + 2'd1;
            rr_cnt_q <= 8'h00;
          end else begin
            rr_ptr_q <= pick;
            rr_cnt_q <= cnt_inc;
          end
        end
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end

  assign out_valid = out_valid_q;
  assign out_queue = out_queue_q;
  assign out_data = out_data_q;
endmodule : qcs_top

/* File: tb/qcs_checker.sv */
`timescale 1ns/100ps

module qcs_checker (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, low
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pready, // apb ready
  input wire logic [31:0] prdata, // apb read data
  input wire logic pslverr, // apb error
  input wire logic in_valid, // descriptor offered
  input wire logic in_ready, // descriptor taken
  input wire logic out_valid, // egress valid
  input wire logic out_ready, // egress accept
  input wire logic [1:0] out_queue, // egress queue
  input wire logic [15:0] out_data // egress handle
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // apb slave answers with exactly one access cycle
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  slverr_qual_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  // map ends at the port table word
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h20 |=> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && !penable && paddr <= 8'h20 && paddr[1:0] == 2'b00
    |=> !pslverr) else $error("mapped access refused");
  // a loaded packet stays whole until the transmitter takes it
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_queue)) else $error("egress descriptor changed while stalled");
  in_stage_a: assert property (in_valid && in_ready |=> !in_ready)
    else $error("ingress stage took two in a row");
endmodule : qcs_checker

bind qcs_top qcs_checker chk_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
  .out_queue(out_queue), .out_data(out_data));

/* File: tb/qcs_classify_schedule_tb.sv */
`timescale 1ns/100ps

module qos_classify_schedule_tb;
  import qcs_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic in_valid = 1'b0, in_tagged = 1'b0, in_is_ip = 1'b0, hold = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00, in_ds = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, pm, dm[4];
  logic [3:0] in_port = 4'h0;
  logic [2:0] in_pcp = 3'h0;
  logic [15:0] in_data = 16'h0, out_data, tm;
  logic [1:0] out_queue;
  logic pready, pslverr, in_ready, out_valid, out_ready, ten, den;
  logic [17:0] expq[$];
  int bad_count = 0, num_checks = 0, seed = 99140, sc[4], ec[4];

  initial forever #4 pclk = ~pclk;

  qcs_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_port(in_port),
    .in_tagged(in_tagged), .in_pcp(in_pcp), .in_is_ip(in_is_ip), .in_ds(in_ds),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_queue(out_queue), .out_data(out_data));
  qcs_sink sink_u (.pclk(pclk), .presetn(presetn), .hold(hold), .slow(slow),
    .out_ready(out_ready));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin bad_count++; end_sim; end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd

  // one descriptor; the gap after each take keeps one per two cycles
  task send(input logic [3:0] p, input logic t, input logic [2:0] c, input logic ip,
    input logic [7:0] ds, input logic [15:0] d);
    int n;
    @(posedge pclk);
    in_valid <= 1'b1; in_port <= p; in_tagged <= t; in_pcp <= c; in_is_ip <= ip;
    in_ds <= ds; in_data <= d;
    n = 0;
    do begin @(posedge pclk); n++; end while (in_ready !== 1'b1 && n < 200);
    if (in_ready !== 1'b1) begin bad_count++; end_sim; end
    in_valid <= 1'b0;
  endtask : send

  task drain;
    int n;
    n = 0;
    while (expq.size() > 0 && n < 2000) begin @(posedge pclk); n++; end
    if (expq.size() > 0) begin bad_count++; end_sim; end
  endtask : drain

  // expected queue from the shadow tables
  function logic [1:0] cls(input logic [3:0] p, input logic t, input logic [2:0] c,
    input logic ip, input logic [7:0] ds);
    logic [5:0] v;
    v = ds[7:2];
    if (den && ip) return dm[v[5:4]][2*v[3:0] +: 2];
    if ((ten || den) && t) return tm[2*c +: 2];
    return pm[2*p +: 2];
  endfunction : cls

  // stall the sink, queue up by port = queue, then release and expect order e
  task sched(input qcs_mode_e m, input string s, input string e);
    logic [1:0] q;
    wr(QCS_CTRL_OFF, {26'h0, m, 4'h1});
    sc = '{0, 0, 0, 0};
    ec = '{0, 0, 0, 0};
    hold <= 1'b1;
    for (int i = 0; i < s.len(); i++) begin
      q = 2'(s[i] - 8'h30);
      send({2'b00, q}, 1'b0, 3'h0, 1'b0, 8'h00, {6'h0, q, 8'(sc[q])});
      sc[q]++;
    end
    if (s.len() == 18) begin
      repeat (4) @(posedge pclk);
      chk({31'h0, in_ready}, 32'h0);
      rd(QCS_STATUS_OFF, 32'h10, 1'b0);
    end
    for (int i = 0; i < e.len(); i++) begin
      q = 2'(e[i] - 8'h30);
      expq.push_back({q, 6'h0, q, 8'(ec[q])});
      ec[q]++;
    end
    hold <= 1'b0;
    drain;
    $display("test sched %0d done", m);
  endtask : sched

  // egress watcher compares each taken descriptor with the oldest note
  always @(posedge pclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      chk({14'h0, out_queue, out_data}, expq.size() > 0 ? {14'h0, expq.pop_front()} : 32'hffff_ffff);
    end
  end

  initial begin
    logic [31:0] r;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(QCS_CTRL_OFF, 32'h1, 1'b0);
    rd(QCS_WEIGHT_OFF, QCS_WEIGHT_RST, 1'b0);
    rd(QCS_TAG_MAP_OFF, {16'h0, QCS_TAG_MAP_RST}, 1'b0);
    rd(QCS_PORT_MAP_OFF, 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    $display("test reset done");
    slow <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      ten = k[0];
      den = k[1];
      pm = $random(seed);
      tm = 16'($random(seed));
      wr(QCS_CTRL_OFF, {26'h0, 3'h0, den, ten, 1'b1});
      wr(QCS_PORT_MAP_OFF, pm);
      wr(QCS_TAG_MAP_OFF, {16'h0, tm});
      for (int w = 0; w < 4; w++) begin
        dm[w] = $random(seed);
        wr(QCS_DS_MAP0_OFF + 8'(4 * w), dm[w]);
      end
      rd(QCS_PORT_MAP_OFF, pm, 1'b0);
      for (int i = 0; i < 12; i++) begin
        r = $random(seed);
        expq.push_back({cls(r[3:0], r[4], r[7:5], r[8], r[16:9]), r[31:16]});
        send(r[3:0], r[4], r[7:5], r[8], r[16:9], r[31:16]);
        drain;
      end
      $display("test classify %0d done", k);
    end
    slow <= 1'b0;
    wr(QCS_PORT_MAP_OFF, 32'h0000_00e4);
    wr(QCS_WEIGHT_OFF, 32'h0403_0201);
    sched(QCS_MODE_SP, "011233", "033211");
    sched(QCS_MODE_WRR, "0000111122223333", "0112223333011200");
    sched(QCS_MODE_HYB, "0331122220", "0331122220");
    sched(QCS_MODE_EQU, "00112233", "01230123");
    slow <= 1'b1;
    sched(QCS_MODE_SP, "000000000000000000", "000000000000000000");
    end_sim;
  end
endmodule : qos_classify_schedule_tb

/* File: tb/qcs_sink.sv */
`timescale 1ns/100ps

module qcs_sink (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, low
  input wire logic hold, // stall every grant
  input wire logic slow, // random stalls
  output logic out_ready // transmitter accepts
);
  int sk_seed = 99140;
  // ready only moves just after an edge, like a real transmitter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) out_ready <= 1'b0;
    else out_ready <= !hold && (!slow || ($random(sk_seed) & 1) == 0);
  end
endmodule : qcs_sink
